// >>> logic/pdt_pkg.sv
package pdt_pkg;

  // --------------------------------------------------------------------
  // Structure
  // --------------------------------------------------------------------
  localparam int NUM_PAIRS = 4;
  localparam int NUM_TIMERS = 8;
  localparam int APB_AW = 20;

  // --------------------------------------------------------------------
  // Register indices (byte address = 4 * index)
  // --------------------------------------------------------------------
  localparam logic [15:0] PAIR_A_LOWER_CTRL_IDX = 16'hff30;
  localparam logic [15:0] PAIR_A_UPPER_CTRL_IDX = 16'hff31;
  // Timer t control sits at CTRL_BASE_IDX + t
  localparam logic [15:0] CTRL_BASE_IDX = PAIR_A_LOWER_CTRL_IDX;
  localparam logic [15:0] PRESC_BASE_IDX = 16'hff38;
  localparam logic [15:0] RELOAD_BASE_IDX = 16'hff50;
  localparam logic [15:0] COMPARE_BASE_IDX = 16'hff58;
  localparam logic [15:0] COUNT_BASE_IDX = 16'hff60;

  // --------------------------------------------------------------------
  // Control register fields
  // --------------------------------------------------------------------
  localparam int CTL_MODE_BIT = 7;
  localparam int CTL_NR_BIT = 6;
  localparam int CTL_RSV_BIT = 4;
  localparam int CTL_OE_BIT = 3;
  localparam int CTL_RUN_BIT = 2;
  localparam int CTL_PRESET_BIT = 1;
  localparam int CTL_CKSEL_BIT = 0;
  localparam logic [7:0] CTL_LOWER_RD_MASK = 8'hdd;
  localparam logic [7:0] CTL_UPPER_RD_MASK = 8'h1d;

  // --------------------------------------------------------------------
  // Prescaler register fields
  // --------------------------------------------------------------------
  localparam int PS_GATE_BIT = 4;
  localparam int PS_SRC_BIT = 3;
  localparam int PS_DIV_LSB = 0;
  localparam int PS_DIV_W = 3;
  localparam logic [7:0] PS_RD_MASK = 8'h1f;

  // --------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PRESC_RST = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'hff;
  localparam logic [7:0] COMPARE_RST = 8'h00;

  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int SLOW_OSC_HZ = 32_768;
  localparam int FAST_OSC_HZ = 4_000_000;
  localparam int SLOW_DIV_DEF = CLK_HZ / SLOW_OSC_HZ;
  localparam int FAST_DIV_DEF = CLK_HZ / FAST_OSC_HZ;
  localparam logic [4:0] NR_SLOW_PERIODS = 5'd16;

  typedef enum logic [2:0] {K_NONE, K_CTRL, K_PRESC, K_RELOAD, K_COMPARE, K_COUNT} pdt_kind_e;

  // Fast source: /1 /2 /8 /32 /64 /256 /1024 /4096 as a shift
  function automatic logic [3:0] fast_shift(input logic [2:0] code);
    logic [3:0] s;
    s = 4'd0;
    case (code)
      3'd0: s = 4'd0;
      3'd1: s = 4'd1;
      3'd2: s = 4'd3;
      3'd3: s = 4'd5;
      3'd4: s = 4'd6;
      3'd5: s = 4'd8;
      3'd6: s = 4'd10;
      default: s = 4'd12;
    endcase
    return s;
  endfunction

endpackage

// >>> logic/pdt_timer.sv
`timescale 1ns/1ns
// Contract
// RULE_01: Four pairs, each 16-bit down counter.
// RULE_02: Width bit: 0 two 8-bit, 1 one 16-bit.
// RULE_03: 8-bit mode: each timer own control bits.
// RULE_04: 16-bit: lower underflow clocks upper timer.
// RULE_05: 16-bit: run/preset/clock lower, output enable upper.
// RULE_06: 16-bit: upper clock setting ignored.
// RULE_07: Clock select: 0 prescaler, 1 external pin.
// RULE_08: External clock pin shared per timer pair.
// RULE_09: Noise filter enable per pair, reset 0.
// RULE_10: Filter drops pulses under 16 slow periods.
// RULE_11: Event pulses at least 32 slow periods.
// RULE_12: Prescaler source: 1 slow, 0 fast.
// RULE_13: Software enables fast oscillator before use.
// RULE_14: Fast divisions 1,2,8,32,64,256,1024,4096.
// RULE_15: Slow divisions 1 through 128 by powers.
// RULE_16: Prescaled clock passes only while gate set.
// RULE_17: Reload/compare waveform on pin when enabled.
// RULE_18: Timer 1, 5 underflows exported.
// RULE_19: Preset reads 0, D4 stores, unused zero.
// RULE_20: Preset loads reload now; 16-bit loads all.
// RULE_21: Underflow flags, reloads, keeps counting.
// RULE_22: Count equals compare gives match pulse.
// RULE_23: Run starts counting; stop holds count.
// RULE_24: Synchronise events, count on falling edges.
// RULE_25: Everything resets to zero, timers stopped; reload registers reset to 8'hff instead.
module pdt_timer
  #(
    parameter int unsigned SLOW_DIV = pdt_pkg::SLOW_DIV_DEF,
    parameter int unsigned FAST_DIV = pdt_pkg::FAST_DIV_DEF
  )
  (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [pdt_pkg::APB_AW-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic [pdt_pkg::NUM_PAIRS-1:0] EVENT_PIN_I,
    output logic [pdt_pkg::NUM_PAIRS-1:0] TIMER_WAVE_OUTPUT_PIN_O,
    output logic [pdt_pkg::NUM_TIMERS-1:0] UNDERFLOW_O,
    output logic [pdt_pkg::NUM_TIMERS-1:0] MATCH_O,
    output logic SERIAL_CLK_SRC_O,
    output logic FRAME_SRC_O
  );
  import pdt_pkg::*;

  logic [7:0] ctrl_q [NUM_TIMERS];
  logic [7:0] presc_q [NUM_TIMERS];
  logic [7:0] reload_q [NUM_TIMERS];
  logic [7:0] compare_q [NUM_TIMERS];
  logic [15:0] cnt_all [NUM_PAIRS];
  logic [NUM_TIMERS-1:0] preset_wr, int_tick, sel_tick, uf_ev, cm_ev, wave_q;
  logic [NUM_PAIRS-1:0] ext_fall;

  // ------------------------------------------------------------------
  // Oscillator tick dividers and prescaler chains
  // ------------------------------------------------------------------
  logic [11:0] slow_div_q, fast_div_q, fast_ps_q;
  logic slow_tick_q, fast_tick_q;
  logic [6:0] slow_ps_q;

  // Shared ripple counts; each timer taps its own division
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      slow_div_q <= 12'h000;
      fast_div_q <= 12'h000;
      slow_tick_q <= 1'b0;
      fast_tick_q <= 1'b0;
      slow_ps_q <= 7'h00;
      fast_ps_q <= 12'h000;
    end
    else
    begin
      slow_div_q <= (slow_div_q == 12'(SLOW_DIV - 1)) ? 12'h000 : slow_div_q + 12'h001;
      fast_div_q <= (fast_div_q == 12'(FAST_DIV - 1)) ? 12'h000 : fast_div_q + 12'h001;
      slow_tick_q <= (slow_div_q == 12'(SLOW_DIV - 1));
      fast_tick_q <= (fast_div_q == 12'(FAST_DIV - 1));
      if (slow_tick_q)
        slow_ps_q <= slow_ps_q + 7'h01;
      if (fast_tick_q)
        fast_ps_q <= fast_ps_q + 12'h001;
    end
  end

  for (genvar t = 0; t < NUM_TIMERS; t++)
  begin : g_timer
    logic [2:0] div;
    logic [6:0] smask;
    logic [11:0] fmask;
    logic src_tick;
    assign div = presc_q[t][PS_DIV_LSB +: PS_DIV_W];
    assign smask = 7'((8'h01 << div) - 8'h01); // RULE_15
    assign fmask = 12'((13'h0001 << fast_shift(div)) - 13'h0001); // RULE_14
    assign src_tick = presc_q[t][PS_SRC_BIT] ? (slow_tick_q & (&(slow_ps_q | ~smask)))
                                             : (fast_tick_q & (&(fast_ps_q | ~fmask))); // RULE_12
    assign int_tick[t] = presc_q[t][PS_GATE_BIT] & src_tick; // RULE_16
    assign sel_tick[t] = ctrl_q[t][CTL_CKSEL_BIT] ? ext_fall[t / 2] : int_tick[t]; // RULE_07 RULE_08
  end

  // ------------------------------------------------------------------
  // Per pair: event input path and counter
  // ------------------------------------------------------------------
  for (genvar p = 0; p < NUM_PAIRS; p++)
  begin : g_pair
    localparam int L = 2 * p;
    localparam int H = 2 * p + 1;
    logic ev_s1_q, ev_s2_q;
    logic nr_lvl_q;
    logic [4:0] nr_cnt_q;
    logic ext_lvl;
    logic ext_prev_q;
    logic [15:0] cnt_q, cnt_d;
    logic mode16;
    logic tick_l, tick_h, uf_l, uf_h, cm_l, cm_h;

    always_ff @(posedge CLK_I)
    begin
      if (RESET_I)
      begin
        ev_s1_q <= 1'b0;
        ev_s2_q <= 1'b0;
        ext_prev_q <= 1'b0;
      end
      else
      begin
        ev_s1_q <= EVENT_PIN_I[p]; // RULE_24
        ev_s2_q <= ev_s1_q;
        ext_prev_q <= ext_lvl;
      end
    end

    // Level must hold 16 slow periods before it is believed
    always_ff @(posedge CLK_I)
    begin
      if (RESET_I)
      begin
        nr_lvl_q <= 1'b0;
        nr_cnt_q <= 5'd0;
      end
      else if (ev_s2_q == nr_lvl_q)
        nr_cnt_q <= 5'd0;
      else if (slow_tick_q)
      begin
        if (nr_cnt_q == NR_SLOW_PERIODS - 5'd1) // RULE_10
        begin
          nr_lvl_q <= ev_s2_q;
          nr_cnt_q <= 5'd0;
        end
        else
          nr_cnt_q <= nr_cnt_q + 5'd1;
      end
    end

    assign ext_lvl = ctrl_q[L][CTL_NR_BIT] ? nr_lvl_q : ev_s2_q; // RULE_09

    assign ext_fall[p] = ext_prev_q & ~ext_lvl; // RULE_24
    assign mode16 = ctrl_q[L][CTL_MODE_BIT]; // RULE_02

    always_comb
    begin
      tick_l = ctrl_q[L][CTL_RUN_BIT] & sel_tick[L]; // RULE_23
      tick_h = ctrl_q[H][CTL_RUN_BIT] & sel_tick[H];
      cnt_d = cnt_q;
      uf_l = 1'b0;
      uf_h = 1'b0;
      cm_l = 1'b0;
      cm_h = 1'b0;
      if (mode16)
      begin
        // Upper byte steps only on lower-byte borrow
        if (preset_wr[L]) // RULE_05 RULE_20
          cnt_d = {reload_q[H], reload_q[L]};
        else if (tick_l) // RULE_04 RULE_06
        begin
          if (cnt_q == 16'h0000)
          begin
            cnt_d = {reload_q[H], reload_q[L]}; // RULE_21
            uf_h = 1'b1;
          end
          else
          begin
            cnt_d = cnt_q - 16'h0001;
            cm_h = (cnt_d == {compare_q[H], compare_q[L]}); // RULE_22
          end
        end
      end
      else
      begin
        if (preset_wr[L]) // RULE_03 RULE_20
          cnt_d[7:0] = reload_q[L];
        else if (tick_l)
        begin
          if (cnt_q[7:0] == 8'h00)
          begin
            cnt_d[7:0] = reload_q[L]; // RULE_21
            uf_l = 1'b1;
          end
          else
          begin
            cnt_d[7:0] = cnt_q[7:0] - 8'h01;
            cm_l = (cnt_d[7:0] == compare_q[L]); // RULE_22
          end
        end
        if (preset_wr[H]) // RULE_03 RULE_20
          cnt_d[15:8] = reload_q[H];
        else if (tick_h)
        begin
          if (cnt_q[15:8] == 8'h00)
          begin
            cnt_d[15:8] = reload_q[H]; // RULE_21
            uf_h = 1'b1;
          end
          else
          begin
            cnt_d[15:8] = cnt_q[15:8] - 8'h01;
            cm_h = (cnt_d[15:8] == compare_q[H]); // RULE_22
          end
        end
      end
    end

    always_ff @(posedge CLK_I)
    begin
      if (RESET_I)
        cnt_q <= 16'h0000;
      else
        cnt_q <= cnt_d; // RULE_01
    end

    assign cnt_all[p] = cnt_q;
    assign uf_ev[L] = uf_l;
    assign uf_ev[H] = uf_h;
    assign cm_ev[L] = cm_l;
    assign cm_ev[H] = cm_h;
  end

  // ------------------------------------------------------------------
  // Waveform, event pulses and pins
  // ------------------------------------------------------------------
  // Low from reload until compare hit, then high until underflow
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
      wave_q <= '0;
    else
      for (int t = 0; t < NUM_TIMERS; t++)
        if (uf_ev[t])
          wave_q[t] <= 1'b0; // RULE_17
        else if (cm_ev[t])
          wave_q[t] <= 1'b1;
  end

  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
      TIMER_WAVE_OUTPUT_PIN_O <= '0; // RULE_25
    else
      for (int p = 0; p < NUM_PAIRS; p++)
        if (ctrl_q[2 * p][CTL_MODE_BIT])
          TIMER_WAVE_OUTPUT_PIN_O[p] <= ctrl_q[2 * p + 1][CTL_OE_BIT] & wave_q[2 * p + 1]; // RULE_05
        else
          TIMER_WAVE_OUTPUT_PIN_O[p] <= (ctrl_q[2 * p][CTL_OE_BIT] & wave_q[2 * p])
                                      | (ctrl_q[2 * p + 1][CTL_OE_BIT] & wave_q[2 * p + 1]); // RULE_17
  end

  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      UNDERFLOW_O <= '0;
      MATCH_O <= '0;
      SERIAL_CLK_SRC_O <= 1'b0;
      FRAME_SRC_O <= 1'b0;
    end
    else
    begin
      UNDERFLOW_O <= uf_ev; // RULE_21
      MATCH_O <= cm_ev; // RULE_22
      SERIAL_CLK_SRC_O <= uf_ev[1]; // RULE_18
      FRAME_SRC_O <= uf_ev[5]; // RULE_18
    end
  end

  // ------------------------------------------------------------------
  // APB slave: one wait state, answer registered
  // ------------------------------------------------------------------
  logic [17:0] idx;
  logic [14:0] grp;
  logic [2:0] dec_t;
  pdt_kind_e dec_kind;
  logic [7:0] rd_byte;
  logic bus_wr, acc_first;

  assign idx = PADDR_I[APB_AW-1:2];
  assign grp = idx[17:3];
  assign dec_t = idx[2:0];
  assign acc_first = PSEL_I & PENABLE_I & ~PREADY_O;

  always_comb
  begin
    if (PADDR_I[1:0] != 2'b00)
      dec_kind = K_NONE;
    else if (grp == 15'(CTRL_BASE_IDX >> 3))
      dec_kind = K_CTRL;
    else if (grp == 15'(PRESC_BASE_IDX >> 3))
      dec_kind = K_PRESC;
    else if (grp == 15'(RELOAD_BASE_IDX >> 3))
      dec_kind = K_RELOAD;
    else if (grp == 15'(COMPARE_BASE_IDX >> 3))
      dec_kind = K_COMPARE;
    else if (grp == 15'(COUNT_BASE_IDX >> 3))
      dec_kind = K_COUNT;
    else
      dec_kind = K_NONE;
  end

  always_comb
  begin
    rd_byte = 8'h00;
    case (dec_kind)
      K_CTRL:
        rd_byte = ctrl_q[dec_t] & (dec_t[0] ? CTL_UPPER_RD_MASK : CTL_LOWER_RD_MASK); // RULE_19
      K_PRESC:
        rd_byte = presc_q[dec_t] & PS_RD_MASK;
      K_RELOAD:
        rd_byte = reload_q[dec_t];
      K_COMPARE:
        rd_byte = compare_q[dec_t];
      K_COUNT:
        rd_byte = dec_t[0] ? cnt_all[dec_t[2:1]][15:8] : cnt_all[dec_t[2:1]][7:0];
      default:
        rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
    end
    else
    begin
      PREADY_O <= acc_first;
      PSLVERR_O <= acc_first & (dec_kind == K_NONE);
      if (acc_first & ~PWRITE_I)
        PRDATA_O <= {24'h00_0000, rd_byte};
    end
  end

  // Writes land on the edge that samples PREADY_O high
  assign bus_wr = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & PSTRB_I[0];

  always_comb
  begin
    for (int t = 0; t < NUM_TIMERS; t++)
      preset_wr[t] = bus_wr & (dec_kind == K_CTRL) & (dec_t == 3'(t)) & PWDATA_I[CTL_PRESET_BIT]; // RULE_20
  end

  // Preset is a strobe and never stored, so it reads 0
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      for (int t = 0; t < NUM_TIMERS; t++)
      begin
        ctrl_q[t] <= CTRL_RST; // RULE_25
        presc_q[t] <= PRESC_RST;
        reload_q[t] <= RELOAD_RST;
        compare_q[t] <= COMPARE_RST;
      end
    end
    else if (bus_wr)
    begin
      if (dec_kind == K_CTRL)
        ctrl_q[dec_t] <= PWDATA_I[7:0] & (dec_t[0] ? CTL_UPPER_RD_MASK : CTL_LOWER_RD_MASK); // RULE_19
      else if (dec_kind == K_PRESC)
        presc_q[dec_t] <= PWDATA_I[7:0] & PS_RD_MASK;
      else if (dec_kind == K_RELOAD)
        reload_q[dec_t] <= PWDATA_I[7:0];
      else if (dec_kind == K_COMPARE)
        compare_q[dec_t] <= PWDATA_I[7:0];
    end
  end

endmodule

// >>> verification/pdt_timer_sva.sv
`timescale 1ns/1ns
module pdt_timer_chk
  #(
    parameter int unsigned SLOW_DIV = 4,
    parameter int unsigned FAST_DIV = 2
  )
  (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [pdt_pkg::APB_AW-1:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic [pdt_pkg::NUM_PAIRS-1:0] TIMER_WAVE_OUTPUT_PIN_O,
    input wire logic [pdt_pkg::NUM_TIMERS-1:0] UNDERFLOW_O,
    input wire logic [pdt_pkg::NUM_TIMERS-1:0] MATCH_O,
    input wire logic SERIAL_CLK_SRC_O,
    input wire logic FRAME_SRC_O
  );
  import pdt_pkg::*;
  logic [15:0] idx;
  logic rd_ok;
  assign idx = PADDR_I[17:2];
  assign rd_ok = PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I && PADDR_I[19:18] == 2'b00 && PADDR_I[1:0] == 2'b00;
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);
  sequence s_access;
    PSEL_I && PENABLE_I && !PREADY_O;
  endsequence
  sequence s_answer;
    PREADY_O ##1 !PREADY_O;
  endsequence
  property p_answer;
    s_access |=> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("ready not a single pulse after access");
  property p_err;
    PSLVERR_O |-> PREADY_O;
  endproperty
  a_err: assert property (p_err) else $error("error outside ready");
  property p_ctrl_rd;
    rd_ok && (idx & 16'hfff8) == CTRL_BASE_IDX |-> PRDATA_O[31:8] == 24'h0 && !PRDATA_O[5] && !PRDATA_O[1];
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read shows unused or strobe bit");
  property p_upper_rd;
    rd_ok && (idx & 16'hfff8) == CTRL_BASE_IDX && idx[0] |-> PRDATA_O[7:5] == 3'b000;
  endproperty
  a_upper_rd: assert property (p_upper_rd) else $error("upper control high bits not zero");
  property p_presc_rd;
    rd_ok && (idx & 16'hfff8) == PRESC_BASE_IDX |-> PRDATA_O[31:5] == 27'h0;
  endproperty
  a_presc_rd: assert property (p_presc_rd) else $error("prescaler read shows unused bits");
  property p_serial;
    SERIAL_CLK_SRC_O == UNDERFLOW_O[1];
  endproperty
  a_serial: assert property (p_serial) else $error("serial source differs from timer 1 underflow");
  property p_frame;
    FRAME_SRC_O == UNDERFLOW_O[5];
  endproperty
  a_frame: assert property (p_frame) else $error("frame source differs from timer 5 underflow");
  property p_after_reset;
    $fell(RESET_I) |-> UNDERFLOW_O == 8'h00 && MATCH_O == 8'h00 && TIMER_WAVE_OUTPUT_PIN_O == 4'h0 && !PREADY_O;
  endproperty
  a_after_reset: assert property (p_after_reset) else $error("outputs active after reset");
  // Ticks are at least two cycles apart, so one underflow per bit per tick
  property p_uf_single;
    SLOW_DIV > 1 && FAST_DIV > 1 && UNDERFLOW_O != 8'h00 |=> (UNDERFLOW_O & $past(UNDERFLOW_O)) == 8'h00;
  endproperty
  a_uf_single: assert property (p_uf_single) else $error("underflow held two cycles");
endmodule

bind pdt_timer pdt_timer_chk #(.SLOW_DIV(SLOW_DIV), .FAST_DIV(FAST_DIV)) u_chk
  (
    .CLK_I(CLK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
    .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .TIMER_WAVE_OUTPUT_PIN_O(TIMER_WAVE_OUTPUT_PIN_O), .UNDERFLOW_O(UNDERFLOW_O), .MATCH_O(MATCH_O),
    .SERIAL_CLK_SRC_O(SERIAL_CLK_SRC_O), .FRAME_SRC_O(FRAME_SRC_O)
  );

// >>> verification/pdt_event_src.sv
`timescale 1ns/1ns
module pdt_event_src
  (
    input wire logic clk_i,
    output logic [3:0] pin_o
  );
  // Pins idle high as with a pull-up; a count is the falling edge
  initial pin_o = 4'hf;
  // Filtered sources need w of 32 slow periods or more
  task automatic burst(input int p, input int n, input int w);
    repeat (n)
    begin
      @(posedge clk_i);
      pin_o[p] <= 1'b0;
      repeat (w) @(posedge clk_i);
      pin_o[p] <= 1'b1;
      repeat (w) @(posedge clk_i);
    end
  endtask
endmodule

// >>> verification/pdt_timer_tb.sv
`timescale 1ns/1ns
module pdt_timer_tb;
  import pdt_pkg::*;
  localparam int SD = 4;
  localparam int FD = 2;
  logic clk, rst, psel, pen, pwr, rdy, slverr, sclk, fsrc;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, ev_pin, wave;
  logic [7:0] ufl, mch;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int err_count, check_count, uf[8], mt[8], ser, frm;
  int fr[8] = '{1, 2, 8, 32, 64, 256, 1024, 4096};

  pdt_timer #(.SLOW_DIV(SD), .FAST_DIV(FD)) uut
    (
      .CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(rdy), .PSLVERR_O(slverr),
      .EVENT_PIN_I(ev_pin), .TIMER_WAVE_OUTPUT_PIN_O(wave), .UNDERFLOW_O(ufl), .MATCH_O(mch),
      .SERIAL_CLK_SRC_O(sclk), .FRAME_SRC_O(fsrc)
    );
  pdt_event_src ev (.clk_i(clk), .pin_o(ev_pin));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic hang(input string nm);
    err_count++;
    $display("BAD %s expected answer seen timeout", nm);
    stop_test();
  endtask

  // ----
  // Bus master: expected answer noted before the transfer
  // ----
  task automatic apb(input logic w, input logic [15:0] ix, input logic [7:0] d, input logic [3:0] sb,
                     input logic [7:0] x, input logic er);
    int n;
    exp_q.push_back({!w, er, 24'h0, x});
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= {24'h0, d};
    pstrb <= sb;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rdy !== 1'b1 && n < 16);
    if (rdy !== 1'b1)
      hang("pready");
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] ix, input logic [7:0] d);
    apb(1'b1, ix, d, 4'hf, 8'h00, 1'b0);
  endtask

  task automatic rd(input logic [15:0] ix, input logic [7:0] x);
    apb(1'b0, ix, 8'h00, 4'hf, x, 1'b0);
  endtask

  task automatic gap(input int t, output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ufl[t] !== 1'b1 && n < 20000);
    if (ufl[t] !== 1'b1)
      hang("underflow");
  endtask

  // ----
  // Watchers
  // ----
  always @(posedge clk)
  begin
    for (int i = 0; i < 8; i++)
    begin
      uf[i] += int'(ufl[i] === 1'b1);
      mt[i] += int'(mch[i] === 1'b1);
    end
    ser += int'(sclk === 1'b1);
    frm += int'(fsrc === 1'b1);
    if (psel && pen && rdy === 1'b1)
    begin
      e = exp_q.pop_front();
      chk("pslverr", {31'h0, e[32]}, {31'h0, slverr});
      if (e[33])
        chk("prdata", e[31:0], prdata);
    end
  end

  initial
  begin
    int b, n, r, u;
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    void'($urandom(59));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int t = 0; t < 8; t++)
    begin
      rd(16'(CTRL_BASE_IDX + t), 8'h00);
      rd(16'(PRESC_BASE_IDX + t), 8'h00);
      rd(16'(RELOAD_BASE_IDX + t), 8'hff);
    end
    wr(16'hff37, 8'hff);
    rd(16'hff37, 8'h1d);
    wr(16'hff36, 8'hf9);
    rd(16'hff36, 8'hd9);
    wr(16'hff36, 8'h02);
    rd(16'hff36, 8'h00);
    wr(16'hff37, 8'h00);
    apb(1'b1, RELOAD_BASE_IDX, 8'h12, 4'h0, 8'h00, 1'b0);
    rd(RELOAD_BASE_IDX, 8'hff);
    apb(1'b0, 16'h1234, 8'h00, 4'hf, 8'h00, 1'b1);
    $display("test registers done");
    r = 2 + $urandom % 6;
    wr(16'hff51, 8'(r));
    wr(16'hff31, 8'h07);
    ev.burst(1, 2, 4);
    rd(16'hff61, 8'(r));
    b = ser;
    u = uf[0];
    ev.burst(0, r, 4);
    rd(16'hff61, 8'h00);
    ev.burst(0, 1, 4);
    rd(16'hff61, 8'(r));
    chk("serial", 1, ser - b);
    chk("uf0", 0, uf[0] - u);
    wr(16'hff31, 8'h01);
    ev.burst(0, 2, 4);
    rd(16'hff61, 8'(r));
    // Filter on before preset, its switch-on may pass one edge
    wr(16'hff30, 8'h40);
    wr(16'hff31, 8'h07);
    ev.burst(0, 3, 20);
    rd(16'hff61, 8'(r));
    ev.burst(0, 2, 36 * SD);
    rd(16'hff61, 8'(r - 2));
    wr(16'hff30, 8'h00);
    wr(16'hff31, 8'h00);
    $display("test events done");
    wr(16'hff54, 8'h00);
    wr(16'hff55, 8'h01);
    wr(16'hff35, 8'h08);
    // Mode first, so that the preset already sees the pair as 16 bits
    wr(16'hff34, 8'h80);
    wr(16'hff34, 8'h87);
    b = frm;
    u = uf[4];
    ev.burst(2, 1, 4);
    rd(16'hff64, 8'hff);
    rd(16'hff65, 8'h00);
    ev.burst(2, 256, 4);
    rd(16'hff65, 8'h01);
    chk("frame", 1, frm - b);
    chk("uf4", 0, uf[4] - u);
    wr(16'hff34, 8'h00);
    $display("test cascade done");
    wr(16'hff52, 8'h00);
    wr(16'hff32, 8'h06);
    b = uf[2];
    repeat (300) @(posedge clk);
    chk("gated", 0, uf[2] - b);
    // Fast oscillator is taken as running here
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 8; c++)
      begin
        wr(16'hff3a, 8'(16 + 8 * s + c));
        // Skip a pulse still timed by the old setting
        repeat (2) @(posedge clk);
        gap(2, n);
        gap(2, n);
        chk("tick_gap", s ? SD * (1 << c) : FD * fr[c], n);
      end
    wr(16'hff32, 8'h00);
    $display("test prescaler done");
    wr(16'hff56, 8'h04);
    wr(16'hff5e, 8'h02);
    wr(16'hff36, 8'h0f);
    b = mt[6];
    ev.burst(3, 2, 4);
    repeat (4) @(posedge clk);
    chk("match", 1, mt[6] - b);
    chk("wave_set", 1, {31'h0, wave[3]});
    ev.burst(3, 3, 4);
    repeat (4) @(posedge clk);
    chk("wave_clr", 0, {31'h0, wave[3]});
    $display("test wave done");
    stop_test();
  end
endmodule
